// >>> shared/terl_pkg.sv
// Constants and source layout of the timer event request logic
`default_nettype none

package terl_pkg;

  // Source counts per kind
  localparam int unsigned NUM_CHANNELS = 6;
  localparam int unsigned NUM_MATCH    = 16;
  localparam int unsigned NUM_OVF      = 6;
  localparam int unsigned NUM_UNF      = 4;

  // Match flag vector layout: first bit and count per channel
  // ch0 A..D = 0..3, ch1 A,B = 4..5, ch2 = 6..7,
  // ch3 A..D = 8..11, ch4 = 12..13, ch5 = 14..15
  localparam int unsigned MATCH_BASE [NUM_CHANNELS] =
    '{0, 4, 6, 8, 12, 14};
  localparam int unsigned MATCH_COUNT [NUM_CHANNELS] =
    '{4, 2, 2, 4, 2, 2};

  // Compare A flag of each channel is the first bit of its group
  localparam int unsigned A_FLAG_INDEX [NUM_CHANNELS] =
    '{0, 4, 6, 8, 12, 14};

  // Underflow vector bit k belongs to this channel
  localparam int unsigned UNF_CHANNEL [NUM_UNF] = '{1, 2, 4, 5};

  // Reset values of all request and pulse registers
  localparam logic [NUM_MATCH-1:0]    MATCH_RESET = 16'h0000;
  localparam logic [NUM_OVF-1:0]      OVF_RESET   = 6'h00;
  localparam logic [NUM_UNF-1:0]      UNF_RESET   = 4'h0;
  localparam logic [NUM_CHANNELS-1:0] CONV_RESET  = 6'h00;

  // Latency from a flag change to the request output, in cycles
  localparam int unsigned REQ_LATENCY = 1;

  // Request routing state of one match source
  typedef enum logic [1:0] {
    TERL_ROUTE_IDLE    = 2'b00,
    TERL_ROUTE_PENDING = 2'b01
  } terl_route_e;

endpackage : terl_pkg

`default_nettype wire

// >>> core/terl_req_gate.sv
// Registered AND gate of status flags and enable bits
`default_nettype none

module terl_req_gate #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             i_clock,
  input  wire logic             i_reset,
  input  wire logic [WIDTH-1:0] i_flag,
  input  wire logic [WIDTH-1:0] i_enable,
  output var  logic [WIDTH-1:0] o_req
);

  logic [WIDTH-1:0] req_next;

  // Level request, re-evaluated every cycle
  always_comb begin
    req_next = i_flag & i_enable;
  end

  // Register only; reset clears every request
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      o_req <= '0;
    end else begin
      o_req <= req_next;
    end
  end

endmodule : terl_req_gate

`default_nettype wire

// >>> core/terl_top.sv
// Interrupt, transfer and conversion start requests of a timer unit
`default_nettype none

module terl_top (
  input  wire logic                            I_CLOCK,
  input  wire logic                            I_RESET,
  input  wire logic [terl_pkg::NUM_MATCH-1:0]    I_MATCH_STATUS_FLAG,
  input  wire logic [terl_pkg::NUM_MATCH-1:0]    I_MATCH_IRQ_ENABLE,
  input  wire logic [terl_pkg::NUM_OVF-1:0]      I_OVERFLOW_FLAG,
  input  wire logic [terl_pkg::NUM_OVF-1:0]      I_OVERFLOW_IRQ_ENABLE,
  input  wire logic [terl_pkg::NUM_UNF-1:0]      I_UNDERFLOW_FLAG,
  input  wire logic [terl_pkg::NUM_UNF-1:0]      I_UNDERFLOW_IRQ_ENABLE,
  input  wire logic [terl_pkg::NUM_CHANNELS-1:0] I_CONV_TRIGGER_ENABLE,
  input  wire logic [terl_pkg::NUM_MATCH-1:0]    I_TRANSFER_SELECT,
  input  wire logic [terl_pkg::NUM_MATCH-1:0]    I_TRANSFER_ACK,
  output var  logic [terl_pkg::NUM_MATCH-1:0]    O_MATCH_IRQ,
  output var  logic [terl_pkg::NUM_OVF-1:0]      O_OVERFLOW_IRQ,
  output var  logic [terl_pkg::NUM_UNF-1:0]      O_UNDERFLOW_IRQ,
  output var  logic [terl_pkg::NUM_MATCH-1:0]    O_TRANSFER_REQ,
  output var  logic [terl_pkg::NUM_MATCH-1:0]    O_MATCH_FLAG_CLEAR,
  output var  logic [terl_pkg::NUM_CHANNELS-1:0] O_CONVERSION_START
);

  import terl_pkg::*;

  // Transfer routing state, one per match source
  terl_route_e                 route_reg [NUM_MATCH];
  terl_route_e                 route_next [NUM_MATCH];
  logic [NUM_MATCH-1:0]        xfer_cand;
  logic [NUM_MATCH-1:0]        xfer_allow;
  logic [NUM_MATCH-1:0]        ack_taken;
  logic [NUM_MATCH-1:0]        clear_next;
  logic [NUM_MATCH-1:0]        clear_reg;

  // Conversion start edge detection
  logic [NUM_CHANNELS-1:0]     compare_a;
  logic [NUM_CHANNELS-1:0]     compare_a_reg;
  logic [NUM_CHANNELS-1:0]     compare_a_next;
  logic [NUM_CHANNELS-1:0]     conv_next;
  logic [NUM_CHANNELS-1:0]     conv_reg;

  // CPU match requests: one gate for all sixteen sources
  terl_req_gate #(
    .WIDTH (NUM_MATCH)
  ) u_match_gate (
    .i_clock  (I_CLOCK),
    .i_reset  (I_RESET),
    .i_flag   (I_MATCH_STATUS_FLAG),
    .i_enable (I_MATCH_IRQ_ENABLE),
    .o_req    (O_MATCH_IRQ)
  );

  // Overflow requests, one per channel
  terl_req_gate #(
    .WIDTH (NUM_OVF)
  ) u_ovf_gate (
    .i_clock  (I_CLOCK),
    .i_reset  (I_RESET),
    .i_flag   (I_OVERFLOW_FLAG),
    .i_enable (I_OVERFLOW_IRQ_ENABLE),
    .o_req    (O_OVERFLOW_IRQ)
  );

  // Underflow requests; channels 0 and 3 have no bit at all
  terl_req_gate #(
    .WIDTH (NUM_UNF)
  ) u_unf_gate (
    .i_clock  (I_CLOCK),
    .i_reset  (I_RESET),
    .i_flag   (I_UNDERFLOW_FLAG),
    .i_enable (I_UNDERFLOW_IRQ_ENABLE),
    .o_req    (O_UNDERFLOW_IRQ)
  );

  // Transfer candidates: match sources only, never overflow
  always_comb begin
    xfer_cand = I_MATCH_STATUS_FLAG & I_MATCH_IRQ_ENABLE
              & I_TRANSFER_SELECT;
  end

  // Transfer requests; held off while an automatic clear settles
  terl_req_gate #(
    .WIDTH (NUM_MATCH)
  ) u_xfer_gate (
    .i_clock  (I_CLOCK),
    .i_reset  (I_RESET),
    .i_flag   (xfer_cand),
    .i_enable (xfer_allow),
    .o_req    (O_TRANSFER_REQ)
  );

  // Routing next state; an ack counts only against a live request
  always_comb begin
    ack_taken  = I_TRANSFER_ACK & O_TRANSFER_REQ;
    clear_next = ack_taken;
    xfer_allow = '1;
    for (int i = 0; i < NUM_MATCH; i++) begin
      route_next[i] = route_reg[i];
      case (route_reg[i])
        TERL_ROUTE_IDLE: begin
          if (ack_taken[i]) begin
            route_next[i] = TERL_ROUTE_PENDING;
          end
        end
        TERL_ROUTE_PENDING: begin
          // Avoids a second activation before the flag drops
          xfer_allow[i] = 1'b0;
          if (!I_MATCH_STATUS_FLAG[i] && !clear_reg[i]) begin
            route_next[i] = TERL_ROUTE_IDLE;
          end
        end
        default: begin
          route_next[i] = TERL_ROUTE_IDLE;
        end
      endcase
      if (ack_taken[i]) begin
        xfer_allow[i] = 1'b0;
      end
    end
  end

  // Routing registers
  always_ff @(posedge I_CLOCK) begin
    if (I_RESET) begin
      for (int i = 0; i < NUM_MATCH; i++) begin
        route_reg[i] <= TERL_ROUTE_IDLE;
      end
      clear_reg <= MATCH_RESET;
    end else begin
      for (int i = 0; i < NUM_MATCH; i++) begin
        route_reg[i] <= route_next[i];
      end
      clear_reg <= clear_next;
    end
  end

  // Automatic flag clear pulse to the flag owner
  always_comb begin
    O_MATCH_FLAG_CLEAR = clear_reg;
  end

  // Conversion start: rising compare A flag with trigger enabled
  always_comb begin
    for (int c = 0; c < NUM_CHANNELS; c++) begin
      compare_a[c] = I_MATCH_STATUS_FLAG[A_FLAG_INDEX[c]];
    end
    compare_a_next = compare_a;
    // Edge, not level: one request per flag set
    conv_next = compare_a & ~compare_a_reg
              & I_CONV_TRIGGER_ENABLE;
  end

  // Conversion start registers
  always_ff @(posedge I_CLOCK) begin
    if (I_RESET) begin
      compare_a_reg <= CONV_RESET;
      conv_reg      <= CONV_RESET;
    end else begin
      compare_a_reg <= compare_a_next;
      conv_reg      <= conv_next;
    end
  end

  // Pulse goes out straight from its register
  always_comb begin
    O_CONVERSION_START = conv_reg;
  end

  // Helper: history is valid one cycle after reset release
  logic past_ok_reg;
  always_ff @(posedge I_CLOCK) begin
    if (I_RESET) begin
      past_ok_reg <= 1'b0;
    end else begin
      past_ok_reg <= 1'b1;
    end
  end

  default clocking cb @(posedge I_CLOCK);
  endclocking
  default disable iff (I_RESET || !past_ok_reg);

  // Accepted ack followed by clear pulse with no request in the same cycle
  sequence s_ack_taken(int k);
    I_TRANSFER_ACK[k] && O_TRANSFER_REQ[k];
  endsequence

  sequence s_clear_then_quiet(int k);
    O_MATCH_FLAG_CLEAR[k] && !O_TRANSFER_REQ[k];
  endsequence

  a_match_level: assert property (
    O_MATCH_IRQ == $past(I_MATCH_STATUS_FLAG & I_MATCH_IRQ_ENABLE))
    else $error("match request not flag and enable");

  a_match_drop: assert property (
    (O_MATCH_IRQ & ~$past(I_MATCH_STATUS_FLAG)) == MATCH_RESET)
    else $error("match request held after flag clear");

  a_ch3_group: assert property (
    $rose(I_MATCH_STATUS_FLAG[11] && I_MATCH_IRQ_ENABLE[11])
    |=> O_MATCH_IRQ[11])
    else $error("channel 3 compare D request missing");

  a_ovf_level: assert property (
    O_OVERFLOW_IRQ == $past(I_OVERFLOW_FLAG & I_OVERFLOW_IRQ_ENABLE))
    else $error("overflow request not flag and enable");

  a_ovf_ch5: assert property (
    !I_OVERFLOW_FLAG[5] |=> !O_OVERFLOW_IRQ[5])
    else $error("channel 5 overflow request without flag");

  a_unf_level: assert property (
    O_UNDERFLOW_IRQ == $past(I_UNDERFLOW_FLAG & I_UNDERFLOW_IRQ_ENABLE))
    else $error("underflow request not flag and enable");

  a_unf_hold: assert property (
    (I_UNDERFLOW_FLAG[3] && I_UNDERFLOW_IRQ_ENABLE[3]) [*2]
    |-> O_UNDERFLOW_IRQ[3])
    else $error("channel 5 underflow request lost");

  a_xfer_subset: assert property (
    (O_TRANSFER_REQ & ~$past(xfer_cand)) == MATCH_RESET)
    else $error("transfer request without match source");

  a_conv_cause: assert property (
    O_CONVERSION_START[2] |->
    $past(I_CONV_TRIGGER_ENABLE[2]) && $past(compare_a[2])
    && !$past(compare_a_reg[2]))
    else $error("conversion start without compare A set");

  a_conv_source: assert property (
    $rose(I_MATCH_STATUS_FLAG[14]) && I_CONV_TRIGGER_ENABLE[5]
    |=> O_CONVERSION_START[5] ##1 !O_CONVERSION_START[5])
    else $error("channel 5 conversion start not one pulse");

  a_auto_clear: assert property (
    s_ack_taken(0) |=> s_clear_then_quiet(0) ##1 !O_MATCH_FLAG_CLEAR[0])
    else $error("transfer ack did not clear flag once");

  a_no_spurious_clr: assert property (
    O_MATCH_FLAG_CLEAR[6] |-> $past(I_TRANSFER_ACK[6])
    && $past(O_TRANSFER_REQ[6]))
    else $error("flag clear without accepted ack");

  a_level_tracks: assert property (
    (I_MATCH_STATUS_FLAG[4] && I_MATCH_IRQ_ENABLE[4]) ##1
    !I_MATCH_IRQ_ENABLE[4] |-> O_MATCH_IRQ[4] ##1 !O_MATCH_IRQ[4])
    else $error("match request not re-evaluated each cycle");

  // Drops checked on whole vectors; refusals and hold-offs on sample bits
  a_ovf_drop: assert property (
    (O_OVERFLOW_IRQ & ~$past(I_OVERFLOW_FLAG)) == OVF_RESET)
    else $error("overflow request held after flag clear");

  a_unf_drop: assert property (
    (O_UNDERFLOW_IRQ & ~$past(I_UNDERFLOW_FLAG)) == UNF_RESET)
    else $error("underflow request held after flag clear");

  a_unf_needs_en: assert property (
    !I_UNDERFLOW_IRQ_ENABLE[0] |=> !O_UNDERFLOW_IRQ[0])
    else $error("channel 1 underflow request while disabled");

  a_xfer_needs_sel: assert property (
    !I_TRANSFER_SELECT[9] |=> !O_TRANSFER_REQ[9])
    else $error("transfer request on unselected source");

  a_xfer_held_off: assert property (
    route_reg[2] == TERL_ROUTE_PENDING |=> !O_TRANSFER_REQ[2])
    else $error("second transfer request before flag drop");

  a_ack_refused: assert property (
    I_TRANSFER_ACK[3] && !O_TRANSFER_REQ[3] |=> !O_MATCH_FLAG_CLEAR[3])
    else $error("flag clear after ack without request");

  a_clear_one_cycle: assert property (
    O_MATCH_FLAG_CLEAR[12] |=> !O_MATCH_FLAG_CLEAR[12])
    else $error("flag clear pulse longer than one cycle");

  a_conv_needs_en: assert property (
    !I_CONV_TRIGGER_ENABLE[1] |=> !O_CONVERSION_START[1])
    else $error("conversion start while trigger disabled");

  a_conv_no_repeat: assert property (
    compare_a_reg[0] |=> !O_CONVERSION_START[0])
    else $error("conversion start repeated on held flag");

endmodule : terl_top

`default_nettype wire

// >>> testbench/terl_far_model.sv
// Far-side model: flag owner, transfer controller and converter
`default_nettype none
module terl_far_model (
  input  wire logic                               i_clock,
  input  wire logic                               i_reset,
  input  wire logic [terl_pkg::NUM_MATCH-1:0]     i_set,
  input  wire logic [terl_pkg::NUM_MATCH-1:0]     i_cpu_clear,
  input  wire logic [terl_pkg::NUM_MATCH-1:0]     i_grant,
  input  wire logic [terl_pkg::NUM_MATCH-1:0]     i_stray_ack,
  input  wire logic [terl_pkg::NUM_MATCH-1:0]     i_transfer_req,
  input  wire logic [terl_pkg::NUM_MATCH-1:0]     i_flag_clear,
  input  wire logic [terl_pkg::NUM_CHANNELS-1:0]  i_conv_start,
  input  wire logic                               i_conv_accept,
  output var  logic [terl_pkg::NUM_MATCH-1:0]     o_flag,
  output var  logic [terl_pkg::NUM_MATCH-1:0]     o_ack,
  output var  int                                 o_conversions
);
  timeunit 1ns;
  timeprecision 1ps;
  import terl_pkg::*;
  logic [NUM_MATCH-1:0] flag_next;
  logic [NUM_MATCH-1:0] ack_next;
  int                   conv_next;
  // Grant gaps make the controller slow; a stray ack tests refusal
  always_comb begin
    flag_next = (o_flag | i_set) & ~i_flag_clear;
    flag_next = flag_next & ~(i_cpu_clear & o_flag);
    ack_next  = (i_transfer_req & i_grant & ~o_ack) | i_stray_ack;
    conv_next = o_conversions;
    if (i_conv_accept) begin
      conv_next = o_conversions + $countones(i_conv_start);
    end
  end
  // Model registers
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      o_flag        <= '0;
      o_ack         <= '0;
      o_conversions <= 0;
    end else begin
      o_flag        <= flag_next;
      o_ack         <= ack_next;
      o_conversions <= conv_next;
    end
  end
endmodule : terl_far_model
`default_nettype wire

// >>> testbench/test_terl_top.sv
// Self-checking bench of the timer event request logic
`default_nettype none
module test_terl_top;
  timeunit 1ns;
  timeprecision 1ps;
  import terl_pkg::*;
  typedef struct packed {
    logic [15:0] irq;
    logic [5:0]  ovf;
    logic [3:0]  unf;
    logic [15:0] req;
    logic [15:0] clr;
    logic [5:0]  conv;
  } terl_exp_s;
  logic        clk, rst, acc;
  logic [15:0] set_v, cpu_clr, grant, stray, flag, ack, men, tsel;
  logic [15:0] irq, req, clr, blocked, prev_f, exp_req, sel_v;
  logic [5:0]  of, oen, ten, ovf, conv, conv_prev;
  logic [3:0]  uf, ue, unf;
  int          seed, errors, tests_run, conv_count, conv_exp;
  terl_exp_s   notes[$];
  terl_exp_s   e;

  terl_top u_dut (.I_CLOCK(clk), .I_RESET(rst),
    .I_MATCH_STATUS_FLAG(flag), .I_MATCH_IRQ_ENABLE(men),
    .I_OVERFLOW_FLAG(of), .I_OVERFLOW_IRQ_ENABLE(oen),
    .I_UNDERFLOW_FLAG(uf), .I_UNDERFLOW_IRQ_ENABLE(ue),
    .I_CONV_TRIGGER_ENABLE(ten), .I_TRANSFER_SELECT(tsel),
    .I_TRANSFER_ACK(ack), .O_MATCH_IRQ(irq), .O_OVERFLOW_IRQ(ovf),
    .O_UNDERFLOW_IRQ(unf), .O_TRANSFER_REQ(req),
    .O_MATCH_FLAG_CLEAR(clr), .O_CONVERSION_START(conv));
  terl_far_model u_far (.i_clock(clk), .i_reset(rst), .i_set(set_v),
    .i_cpu_clear(cpu_clr), .i_grant(grant), .i_stray_ack(stray),
    .i_transfer_req(req), .i_flag_clear(clr), .i_conv_start(conv),
    .i_conv_accept(acc), .o_flag(flag), .o_ack(ack),
    .o_conversions(conv_count));

  task automatic chk(input string n, input logic [15:0] x, g);
    tests_run++;
    if (g !== x) begin
      errors++;
      $display("ERROR %s expected %h seen %h", n, x, g);
    end
  endtask : chk

  task automatic wrap_up();
    $display("Checks %0d, mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : wrap_up

  // Reference: works from the values sampled at this edge
  task automatic note();
    terl_exp_s x;
    logic [15:0] take;
    take = ack & exp_req;
    x = '0;
    if (rst) begin
      blocked = '0;
      prev_f = '0;
      conv_exp = 0;
      conv_prev = '0;
    end else begin
      // Pulses standing now count only if the converter takes them
      if (acc) begin
        conv_exp += $countones(conv_prev);
      end
      blocked = take | (blocked & flag);
      x.irq = flag & men;
      x.ovf = of & oen;
      x.unf = uf & ue;
      x.req = flag & men & tsel & ~blocked;
      x.clr = take;
      for (int c = 0; c < 6; c++) begin
        x.conv[c] = flag[A_FLAG_INDEX[c]] & ~prev_f[A_FLAG_INDEX[c]] & ten[c];
      end
      prev_f = flag;
      conv_prev = x.conv;
    end
    exp_req = x.req;
    notes.push_back(x);
  endtask : note

  // Random traffic; quiet inputs around a reset
  task automatic drive(input int ph, input bit quiet);
    set_v   <= quiet ? '0 : 16'($random(seed) & $random(seed));
    cpu_clr <= quiet ? '0 : 16'($random(seed) & $random(seed)) & ~sel_v;
    grant   <= 16'($random(seed));
    stray   <= 16'($random(seed) & $random(seed) & $random(seed));
    men <= quiet || ph == 3 ? '0 : 16'($random(seed)) | {16{ph == 1}};
    oen <= quiet ? '0 : 6'($random(seed)) | {6{ph == 1}};
    ue  <= quiet ? '0 : 4'($random(seed)) | {4{ph == 1}};
    ten <= quiet ? '0 : 6'($random(seed)) | {6{ph == 1}};
    of  <= quiet ? '0 : 6'($random(seed) & $random(seed));
    uf  <= quiet ? '0 : 4'($random(seed) & $random(seed));
    acc <= 1'($random(seed)); // Converter accept choice
  endtask : drive

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    seed = 380;
    errors = 0;
    tests_run = 0;
    exp_req = '0;
    rst = 1'b1;
    {set_v, cpu_clr, grant, stray, men, tsel, sel_v} = '0;
    {of, oen, ten, uf, ue, acc} = '0;
    repeat (20) begin
      @(posedge clk);
      note();
    end
    rst <= 1'b0;
    // Phases: random, all enabled, reset mid-run, match enables off
    for (int ph = 0; ph < 4; ph++) begin
      sel_v = 16'($random(seed));
      tsel <= sel_v;
      for (int i = 0; i < 1000; i++) begin
        @(posedge clk);
        note();
        rst <= ph == 2 && i >= 500 && i < 503;
        drive(ph, ph == 2 && i >= 500 && i < 504);
      end
      $display("Phase %0d done", ph);
    end
    repeat (3) begin
      @(posedge clk);
      note();
      drive(3, 1'b1);
    end
    @(posedge clk);
    note();
    #2;
    chk("conversions", 16'(conv_exp), 16'(conv_count));
    wrap_up();
  end

  // Output watcher takes the oldest note each cycle
  always @(posedge clk) begin
    #1;
    if (notes.size() > 0) begin
      e = notes.pop_front();
      chk("match_irq", e.irq, irq);
      chk("overflow_irq", 16'(e.ovf), 16'(ovf));
      chk("underflow_irq", 16'(e.unf), 16'(unf));
      chk("transfer_req", e.req, req);
      chk("flag_clear", e.clr, clr);
      chk("conv_start", 16'(e.conv), 16'(conv));
    end
  end

  // Watchdog well past the expected run length
  initial begin
    repeat (6000) @(posedge clk);
    errors++;
    wrap_up();
  end
endmodule : test_terl_top
`default_nettype wire
